// ==== design/mcu_bus_master.sv ====
`timescale 1ns/1ps
// Overview of operation
// - An extended write first presents the high address byte.
// - The low address byte is held one bus clock before the latch strobe.
// - Latch strobe is high one bus clock, two on a write when wait-ready is low.
// - On a write the latch strobe falls together with chip select.
// - Write data is driven one bus clock before the write strobe.
// - Write strobe is low one clock, six when wait-ready is low.
// - Chip select releases half a bus clock after the write strobe rises.
// - Write data stays until chip select has released.
// - A read presents the high address byte only in its extended form.
// - Read select falls a clock after latch rise; read strobe a clock later, three when wait-ready is low.
// - On a read the bus is released as the read strobe falls.
// - Read strobe is low one clock, five when wait-ready is low.
// - Half a clock after read strobe rise, select releases, bus drives.
module mcu_bus_master
  import mcu_bus_pkg::*;
(
  // Clock and reset
  input  wire logic       core_clk,
  input  wire logic       rst,
  // Command side
  input  wire logic       cmd_valid,
  input  wire logic       cmd_read,
  input  wire logic       cmd_ext,
  input  wire logic [15:0] cmd_addr,
  input  wire logic [7:0] cmd_wdata,
  output logic            cmd_ready,
  output logic            rd_valid,
  output logic [7:0]      rd_data,
  // Peripheral bus
  output logic [7:0]      ext_addr,
  input  wire logic [7:0] ad_in,
  output logic [7:0]      ad_out,
  output logic            ad_oe_n,
  output logic            ale,
  output logic            cs_n,
  output logic            wr_n,
  output logic            rd_n,
  input  wire logic       wait_ready_in,
  output logic            bus_clock_out
);

  bus_state_t  state_r;
  logic [3:0]  cnt_r;
  logic        is_read_r;
  logic        ext_r;
  logic [15:0] addr_r;
  logic [7:0]  wdata_r;
  logic        rise_tick;
  logic        fall_tick;
  logic        clk_level;

  bus_clk_gen #(.DIV(BUS_CLK_DIV)) u_clk (
    .core_clk  (core_clk),
    .rst       (rst),
    .rise_tick (rise_tick),
    .fall_tick (fall_tick),
    .clk_level (clk_level)
  );

  // Length of a phase picked from wait-ready
  function automatic logic [3:0] pick(input logic slow,
                                      input logic [3:0] fast_n,
                                      input logic [3:0] slow_n);
    pick = slow ? slow_n : fast_n;
  endfunction : pick

  logic        last;
  assign last = (cnt_r == 4'h1);

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer
  always_ff @(posedge core_clk) begin
    if (rst) begin
      state_r   <= ST_IDLE;
      cnt_r     <= 4'h0;
      is_read_r <= 1'b0;
      ext_r     <= 1'b0;
      addr_r    <= 16'h0000;
      wdata_r   <= DATA_RST;
    end else begin
      case (state_r)
        ST_IDLE: begin
          if (cmd_valid && rise_tick) begin
            is_read_r <= cmd_read;
            ext_r     <= cmd_ext;
            addr_r    <= cmd_addr;
            wdata_r   <= cmd_wdata;
            if (cmd_ext) begin
              state_r <= ST_HIADDR;
              cnt_r   <= HIGH_ADDR_CLKS;
            end else begin
              state_r <= ST_ADDR;
              cnt_r   <= ADDR_SETUP_CLKS;
            end
          end
        end
        ST_HIADDR: begin
          if (rise_tick) begin
            state_r <= ST_ADDR;
            cnt_r   <= ADDR_SETUP_CLKS;
          end
        end
        ST_ADDR: begin
          if (rise_tick) begin
            state_r <= ST_ALE_HI;
            cnt_r   <= pick(!wait_ready_in, ALE_HI_CLKS, ALE_HI_WAIT_CLKS);
          end
        end
        ST_ALE_HI: begin
          if (rise_tick) begin
            if (is_read_r) begin
              // Chip select one clock after latch rise, regardless of wait
              state_r <= ST_CS_WAIT;
              cnt_r   <= pick(!wait_ready_in, RD_CS_CLKS, RD_CS_WAIT_CLKS);
            end else if (last || wait_ready_in) begin
              state_r <= ST_DSETUP;
              cnt_r   <= DATA_SETUP_CLKS;
            end else begin
              cnt_r <= cnt_r - 4'h1;
            end
          end
        end
        ST_CS_WAIT: begin
          if (rise_tick) begin
            if (last) begin
              state_r <= ST_STROBE;
              cnt_r   <= pick(!wait_ready_in, RD_LO_CLKS, RD_LO_WAIT_CLKS);
            end else begin
              cnt_r <= cnt_r - 4'h1;
            end
          end
        end
        ST_DSETUP: begin
          if (rise_tick) begin
            state_r <= ST_STROBE;
            cnt_r   <= pick(!wait_ready_in, WR_LO_CLKS, WR_LO_WAIT_CLKS);
          end
        end
        ST_STROBE: begin
          if (rise_tick) begin
            if (last) begin
              state_r <= ST_CS_HOLD;
            end else begin
              cnt_r <= cnt_r - 4'h1;
            end
          end
        end
        ST_CS_HOLD: begin
          if (fall_tick) begin
            state_r <= ST_DONE;
          end
        end
        ST_DONE: begin
          if (rise_tick) begin
            state_r <= ST_IDLE;
          end
        end
        default: begin
          state_r <= ST_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registered pins
  always_ff @(posedge core_clk) begin
    if (rst) begin
      ext_addr <= ADDR_RST;
      ad_out   <= DATA_RST;
      ad_oe_n  <= 1'b0;
      ale      <= 1'b0;
      cs_n     <= 1'b1;
      wr_n     <= 1'b1;
      rd_n     <= 1'b1;
      bus_clock_out <= 1'b0;
      cmd_ready <= 1'b0;
    end else begin
      bus_clock_out <= clk_level;
      // Ready drops at the edge that takes the command
      cmd_ready <= (state_r == ST_IDLE) && !(cmd_valid && rise_tick);
      if (state_r == ST_HIADDR) begin
        ext_addr <= addr_r[15:8];
      end
      case (state_r)
        ST_ADDR, ST_ALE_HI, ST_CS_WAIT: ad_out <= addr_r[7:0];
        ST_DSETUP, ST_STROBE, ST_CS_HOLD, ST_DONE: begin
          ad_out <= is_read_r ? addr_r[7:0] : wdata_r;
        end
        default: ad_out <= ad_out;
      endcase
      ale <= (state_r == ST_ALE_HI);
      cs_n <= !((state_r == ST_CS_WAIT) || (state_r == ST_DSETUP) ||
                (state_r == ST_STROBE) || (state_r == ST_CS_HOLD));
      wr_n <= !(state_r == ST_STROBE && !is_read_r);
      rd_n <= !(state_r == ST_STROBE && is_read_r);
      // Read keeps the bus released through the chip select tail
      ad_oe_n <= is_read_r && ((state_r == ST_STROBE) ||
                               (state_r == ST_CS_HOLD));
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read capture at read strobe rise
  always_ff @(posedge core_clk) begin
    if (rst) begin
      rd_data  <= DATA_RST;
      rd_valid <= 1'b0;
    end else begin
      rd_valid <= 1'b0;
      if (state_r == ST_STROBE && is_read_r && rise_tick && last) begin
        rd_data  <= ad_in;
        rd_valid <= 1'b1;
      end
    end
  end

endmodule : mcu_bus_master

// ==== shared/mcu_bus_pkg.sv ====
package mcu_bus_pkg;

  // Bus clock divider: one bus clock period in core cycles (even, >= 2)
  localparam int          BUS_CLK_DIV      = 4;
  localparam int          HALF_DIV         = BUS_CLK_DIV / 2;

  // Phase lengths in bus clocks
  localparam logic [3:0]  ADDR_SETUP_CLKS  = 4'h1;
  localparam logic [3:0]  ALE_HI_CLKS      = 4'h1;
  localparam logic [3:0]  ALE_HI_WAIT_CLKS = 4'h2;
  localparam logic [3:0]  RD_CS_CLKS       = 4'h1;
  localparam logic [3:0]  RD_CS_WAIT_CLKS  = 4'h3;
  localparam logic [3:0]  DATA_SETUP_CLKS  = 4'h1;
  localparam logic [3:0]  WR_LO_CLKS       = 4'h1;
  localparam logic [3:0]  WR_LO_WAIT_CLKS  = 4'h6;
  localparam logic [3:0]  RD_LO_CLKS       = 4'h1;
  localparam logic [3:0]  RD_LO_WAIT_CLKS  = 4'h5;
  localparam logic [3:0]  HIGH_ADDR_CLKS   = 4'h1;

  // Reset levels
  localparam logic [7:0]  DATA_RST         = 8'h00;
  localparam logic [7:0]  ADDR_RST         = 8'h00;

  typedef enum logic [3:0] {
    ST_IDLE, ST_HIADDR, ST_ADDR, ST_ALE_HI, ST_CS_WAIT, ST_DSETUP,
    ST_STROBE, ST_CS_HOLD, ST_DONE
  } bus_state_t;

endpackage : mcu_bus_pkg

// ==== design/bus_clk_gen.sv ====
`timescale 1ns/1ps
// Bus clock generator: square wave out, enables at rising and mid-period
module bus_clk_gen
  import mcu_bus_pkg::*;
#(
  parameter int DIV = BUS_CLK_DIV
) (
  // Clock and reset
  input  wire logic core_clk,
  input  wire logic rst,
  // Ticks
  output logic      rise_tick,
  output logic      fall_tick,
  output logic      clk_level
);

  logic [7:0] cnt_r;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      cnt_r <= 8'h00;
    end else if (cnt_r == 8'(DIV - 1)) begin
      cnt_r <= 8'h00;
    end else begin
      cnt_r <= cnt_r + 8'h01;
    end
  end

  assign rise_tick = (cnt_r == 8'(DIV - 1));
  assign fall_tick = (cnt_r == 8'(DIV / 2 - 1));
  assign clk_level = (cnt_r < 8'(DIV / 2));

endmodule : bus_clk_gen

// ==== dv/mcu_bus_chk.sv ====
`timescale 1ns/1ps
module mcu_bus_chk (
  // Clock and reset
  input wire logic       core_clk,
  input wire logic       rst,
  // Peripheral bus
  input wire logic [7:0] ad_out,
  input wire logic       ad_oe_n,
  input wire logic       ale,
  input wire logic       cs_n,
  input wire logic       wr_n,
  input wire logic       rd_n,
  // Bus clock
  input wire logic       bus_clock_out
);
  logic [4:0] stb_r;
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  sequence tail_s;
    !cs_n[*2] ##1 cs_n;
  endsequence
  sequence oe_back_s;
    ad_oe_n[*2] ##1 !ad_oe_n;
  endsequence
  // Strobe low length in core cycles
  always_ff @(posedge core_clk) begin
    if (rst || (wr_n && rd_n)) stb_r <= 5'h00;
    else stb_r <= stb_r + 5'h01;
  end
  a_addr_setup: assert property ($rose(ale) |->
    ad_out == $past(ad_out, 3) && !ad_oe_n) else $error("addr setup");
  a_ale_width: assert property ($rose(ale) |->
    (ale[*4] ##1 !ale) or (ale[*8] ##1 !ale)) else $error("ale width");
  a_ale_cs: assert property ($fell(ale) |-> $fell(cs_n))
    else $error("cs not with ale fall");
  a_wr_setup: assert property ($fell(wr_n) |-> $past(cs_n, 5) &&
    !$past(cs_n, 4) && ad_out == $past(ad_out, 3)) else $error("wr setup");
  a_wr_width: assert property ($rose(wr_n) |->
    stb_r == 5'h04 || stb_r == 5'h18) else $error("wr width");
  a_wr_tail: assert property ($rose(wr_n) |-> tail_s)
    else $error("wr cs tail");
  a_wr_hold: assert property ($rose(wr_n) |-> $stable(ad_out)[*3])
    else $error("wr data hold");
  a_rd_release: assert property ($fell(rd_n) |-> $rose(ad_oe_n))
    else $error("rd release");
  a_rd_width: assert property ($rose(rd_n) |->
    stb_r == 5'h04 || stb_r == 5'h14) else $error("rd width");
  a_rd_tail: assert property ($rose(rd_n) |-> tail_s and oe_back_s)
    else $error("rd cs tail");
  a_rd_cs_slot: assert property ($fell(rd_n) |->
    ($past(ale, 5) && !$past(ale, 4) && $past(cs_n, 5)) ||
    ($past(ale, 13) && !$past(ale, 12) && $past(cs_n, 13)))
    else $error("rd cs slot");
  a_bus_clock: assert property ($changed(bus_clock_out) |=>
    $stable(bus_clock_out) ##1 $changed(bus_clock_out))
    else $error("bus clock period");
endmodule : mcu_bus_chk

// ==== dv/periph_model.sv ====
`timescale 1ns/1ps
module periph_model (
  // Clock
  input wire logic       core_clk,
  // Bus from the master
  input wire logic [7:0] ext_addr,
  input wire logic [7:0] ad_out,
  input wire logic       ad_oe_n,
  input wire logic       ale,
  input wire logic       cs_n,
  input wire logic       wr_n,
  input wire logic       rd_n,
  // Answer side
  input wire logic       slow,
  output logic [7:0]     ad_in,
  output logic           wait_ready_in
);
  logic [7:0] mem [0:65535];
  logic [7:0] lat_r;
  logic [7:0] last_r = 8'h5a;
  assign wait_ready_in = !slow;
  // Clocked latch capture while ale is high; write lands at the wr_n rise; last value taken each core clock while rd_n is low
  always @(posedge core_clk) if (ale) lat_r <= ad_out;
  always @(posedge wr_n) if (!cs_n) mem[{ext_addr, lat_r}] = ad_out;
  always @(posedge core_clk) if (!rd_n) last_r <= ad_in;
  // Released bus shows the inverse of the last value
  assign ad_in = (!rd_n && !cs_n && ad_oe_n) ? mem[{ext_addr, lat_r}]
                                              : ~last_r;
endmodule : periph_model

// ==== dv/mcu_bus_master_cycles_tb_top.sv ====
`timescale 1ns/1ps
module mcu_bus_master_cycles_tb_top;
  logic        core_clk, rst, cmd_valid, cmd_read, cmd_ext, cmd_ready;
  logic        rd_valid, ad_oe_n, ale, cs_n, wr_n, rd_n, slow;
  logic        wait_ready_in, bus_clock_out;
  logic [15:0] cmd_addr;
  logic [7:0]  cmd_wdata, rd_data, ext_addr, ad_in, ad_out;
  int          n_errors, check_count, cyc, ale_len, stb_len, rd_cnt;
  mcu_bus_master DUT (.core_clk, .rst, .cmd_valid, .cmd_read, .cmd_ext,
    .cmd_addr, .cmd_wdata, .cmd_ready, .rd_valid, .rd_data, .ext_addr,
    .ad_in, .ad_out, .ad_oe_n, .ale, .cs_n, .wr_n, .rd_n, .wait_ready_in,
    .bus_clock_out);
  periph_model u_per (.core_clk, .ext_addr, .ad_out, .ad_oe_n, .ale, .cs_n,
    .wr_n, .rd_n, .slow, .ad_in, .wait_ready_in);
  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    // Phase counters restart while a command is being offered
    if (cmd_valid) begin
      ale_len <= 0;
      stb_len <= 0;
      rd_cnt  <= 0;
    end else begin
      if (ale) ale_len <= ale_len + 1;
      if (!wr_n || !rd_n) stb_len <= stb_len + 1;
      if (rd_valid) rd_cnt <= rd_cnt + 1;
    end
    if (cyc == 3000) begin
      n_errors = n_errors + 1;
      results();
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  task chk(input string n, input logic [15:0] s, input logic [15:0] e);
    check_count++;
    if (s !== e) begin
      n_errors++;
      $display("BAD %s exp %h got %h", n, e, s);
    end
  endtask : chk
  task wait_rdy(input logic v);
    for (int k = 0; k < 200 && cmd_ready !== v; k++) @(negedge core_clk);
    chk("cmd_ready", 16'(cmd_ready), 16'(v));
  endtask : wait_rdy
  task xfer(input logic rd, ext, sl, input logic [15:0] a,
            input logic [7:0] d);
    wait_rdy(1'b1);
    slow = sl;
    cmd_read = rd;
    cmd_ext = ext;
    cmd_addr = a;
    cmd_wdata = d;
    cmd_valid = 1'b1;
    wait_rdy(1'b0);
    cmd_valid = 1'b0;
    wait_rdy(1'b1);
  endtask : xfer
  task lens(input int al, input int sl, input int rv);
    chk("ale_len", 16'(ale_len), 16'(al));
    chk("stb_len", 16'(stb_len), 16'(sl));
    chk("rd_valid", 16'(rd_cnt), 16'(rv));
  endtask : lens
  ////////////////////////////////////////////////////////////////////////////
  task t_wr_ext;
    xfer(1'b0, 1'b1, 1'b0, 16'h1234, 8'ha5);
    chk("ext_addr", 16'(ext_addr), 16'h0012);
    chk("mem", 16'(u_per.mem[16'h1234]), 16'h00a5);
    lens(4, 4, 0);
  endtask : t_wr_ext
  task t_wr_slow;
    xfer(1'b0, 1'b1, 1'b1, 16'h12c3, 8'h3c);
    chk("mem", 16'(u_per.mem[16'h12c3]), 16'h003c);
    lens(8, 24, 0);
  endtask : t_wr_slow
  task t_rd;
    xfer(1'b1, 1'b1, 1'b0, 16'h1234, 8'h00);
    chk("rd_data", 16'(rd_data), 16'h00a5);
    lens(4, 4, 1);
    xfer(1'b1, 1'b1, 1'b1, 16'h12c3, 8'h00);
    chk("rd_data", 16'(rd_data), 16'h003c);
    lens(4, 20, 1);
  endtask : t_rd
  task t_short;
    xfer(1'b0, 1'b0, 1'b0, 16'h9977, 8'h66);
    chk("ext_addr", 16'(ext_addr), 16'h0012);
    chk("mem", 16'(u_per.mem[16'h1277]), 16'h0066);
    lens(4, 4, 0);
    xfer(1'b1, 1'b0, 1'b0, 16'h9977, 8'h00);
    chk("rd_data", 16'(rd_data), 16'h0066);
    lens(4, 4, 1);
  endtask : t_short
  task results;
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : results
  initial begin
    rst = 1'b1;
    cmd_valid = 1'b0;
    cmd_read = 1'b0;
    cmd_ext = 1'b0;
    cmd_addr = 16'h0000;
    cmd_wdata = 8'h00;
    slow = 1'b0;
    repeat (2) @(negedge core_clk);
    rst = 1'b0;
    t_wr_ext();
    t_wr_slow();
    t_rd();
    t_short();
    results();
  end
endmodule : mcu_bus_master_cycles_tb_top
bind mcu_bus_master mcu_bus_chk u_chk (.core_clk, .rst, .ad_out, .ad_oe_n,
  .ale, .cs_n, .wr_n, .rd_n, .bus_clock_out);
